// ===== tb/bpp_board.sv
/* Board on the port pins. Assumes width 8 and one clock. */
`timescale 1ns/100ps
`default_nettype none
module bpp_board(
  input wire logic clk,
  input wire logic [7:0] pinOe, pinOut, pullUpOn, ext, extEn,
  output logic [7:0] pinIn);
  logic tgl = 1'b0;
  always @(posedge clk) tgl <= ~tgl;
  // Undriven pins without pull-up toggle
  assign pinIn = (pinOe & pinOut) | (~pinOe & extEn & ext) |
    (~pinOe & ~extEn & (pullUpOn | {8{tgl}}));
endmodule : bpp_board
`default_nettype wire

// ===== tb/bpp_port_checker.sv
/* Port checker. Assumes width 8, bound to bpp_port. */
`timescale 1ns/100ps
`default_nettype none
module bpp_port_checker(
  input wire logic clk, arst_n, dataWrite, dirWrite, pullWrite,
  input wire logic [7:0] dataIn, dirIn, pullIn, dataOut, pinIn,
  input wire logic [7:0] pinOut, pinOe, pullUpOn);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_calm; (!dataWrite && !dirWrite && $stable(pinIn)) [*6];
  endsequence
  property p_pu; (pullUpOn & pinOe) == 8'h00; endproperty
  a_pu: assert property (p_pu) else $error("pull on output");
  property p_in; s_calm |-> ((dataOut ^ pinIn) & ~pinOe) == 8'h00;
  endproperty
  a_in: assert property (p_in) else $error("input read");
  property p_rd; s_calm |-> ((dataOut ^ pinOut) & pinOe) == 8'h00;
  endproperty
  a_rd: assert property (p_rd) else $error("output read");
  property p_hold; !dataWrite |=> $stable(pinOut); endproperty
  a_hold: assert property (p_hold) else $error("latch lost");
  property p_rst; $rose(arst_n) |-> pinOe == 8'h00; endproperty
  a_rst: assert property (p_rst) else $error("reset dir");
  property p_oe; dirWrite |=> pinOe == $past(dirIn); endproperty
  a_oe: assert property (p_oe) else $error("dir write");
  property p_lat; dataWrite |=> pinOut == $past(dataIn); endproperty
  a_lat: assert property (p_lat) else $error("latch write");
  property p_pul; pullWrite |=> pullUpOn == ($past(pullIn) & ~pinOe);
  endproperty
  a_pul: assert property (p_pul) else $error("pull write");
endmodule : bpp_port_checker
bind bpp_port bpp_port_checker i_chk(.clk, .arst_n, .dataWrite,
  .dirWrite, .pullWrite, .dataIn, .dirIn, .pullIn, .dataOut, .pinIn,
  .pinOut, .pinOe, .pullUpOn);
`default_nettype wire

// ===== tb/bpp_port_tb.sv
/* Port bench with board model. Assumes width 8. */
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_errors++; \
  $display("[FAIL] %0t %h %h", $time, a, e); end end
module bpp_port_tb;
  logic clk = 0, arst_n = 0, dw = 0, rw = 0, pw = 0;
  logic [7:0] v = 8'h00, ext = 8'h3C, extEn = 8'hFF;
  wire logic [7:0] dOut, pIn, pOut, pOe, pUp;
  int n_errors = 0, check_count = 0;
  always #20 clk = ~clk;
  bpp_port i_dut(.clk, .arst_n, .dataWrite(dw), .dataIn(v), .dirWrite(rw),
    .dirIn(v), .pullWrite(pw), .pullIn(v), .dataOut(dOut), .pinIn(pIn),
    .pinOut(pOut), .pinOe(pOe), .pullUpOn(pUp));
  bpp_board i_brd(.clk, .pinOe(pOe), .pinOut(pOut), .pullUpOn(pUp),
    .ext, .extEn, .pinIn(pIn));
  task automatic wr(input logic [2:0] s, input logic [7:0] d);
    {dw, rw, pw} = s;
    v = d;
    @(negedge clk) {dw, rw, pw} = 3'h0;
    repeat (6) @(negedge clk);
  endtask : wr
  task automatic t_mix;
    `CHK(pOe, 8'h00)
    `CHK(dOut, 8'h3C)
    wr(3'h4, 8'hA5);
    `CHK(pOe, 8'h00)
    wr(3'h2, 8'h0F);
    `CHK(pOut, 8'hA5)
    `CHK(dOut, 8'h35)
  endtask : t_mix
  task automatic t_pull;
    extEn = 8'h00;
    wr(3'h1, 8'hFF);
    `CHK(pUp, 8'hF0)
    `CHK(dOut, 8'hF5)
  endtask : t_pull
  task automatic t_keep;
    wr(3'h2, 8'h00);
    wr(3'h2, 8'hFF);
    `CHK({pOut, pUp}, 16'hA500)
    `CHK(dOut, 8'hA5)
  endtask : t_keep
  task automatic end_of_test;
    if (n_errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (16) @(negedge clk);
    arst_n = 1;
    repeat (8) @(negedge clk);
    t_mix;
    t_pull;
    t_keep;
    end_of_test;
  end
  initial begin
    #20000;
    n_errors++;
    end_of_test;
  end
endmodule : bpp_port_tb
`default_nettype wire

// ===== verilog/bpp_pin_sync.sv
/*
  Three-stage input synchroniser for one pin; a change is accepted once
  the second and third stages agree.
  Assumes the pin is asynchronous to clk.
*/
`timescale 1ns/100ps
`default_nettype none
module bpp_pin_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Pin and filtered level
  input wire logic pinIn,
  output logic level
);
  // ****************************************
  // Synchroniser stages
  // ****************************************
  logic [2:0] stages;
  logic [2:0] next_stages;
  logic next_level;

  always_comb begin
    next_stages = {stages[1:0], pinIn};
    next_level = level;
    if (stages[1] == stages[2]) begin
      next_level = stages[2];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stages <= bpp_pkg::SYNC_RESET;
      level <= 1'b0;
    end else begin
      stages <= next_stages;
      level <= next_level;
    end
  end
endmodule : bpp_pin_sync
`default_nettype wire

// ===== verilog/bpp_pkg.sv
/*
  Package for the bidirectional port with pull-up: widths and reset values.
  Assumes a single clock domain and an active-low asynchronous reset.
*/
package bpp_pkg;
  // ****************************************
  // Widths and reset values
  // ****************************************
  localparam int PORT_WIDTH = 8;
  localparam logic [7:0] DIR_RESET = 8'h00;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [7:0] PULL_RESET = 8'h00;
  localparam logic [2:0] SYNC_RESET = 3'h0;
endpackage : bpp_pkg

// ===== verilog/bpp_port.sv
/*
  Bidirectional I/O port: data latch, write-only direction register,
  pull-up control, and read mux of pin level or latch per bit.
  Assumes the processor side is synchronous to clk and the pins are not.
*/
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - A bit's pull-up is connected only while that bit is an input.
// - A port read returns the synchronised pin level for input bits.
// - A port read returns the latch value for output bits.
// - The latch keeps its data across any direction change.
// - The direction register is write-only and has no read path.
// - After reset every bit is an input with its driver off.
// - An input bit has its output driver turned off.
module bpp_port #(
  parameter int WIDTH = bpp_pkg::PORT_WIDTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Processor side
  input wire logic dataWrite,
  input wire logic [WIDTH-1:0] dataIn,
  input wire logic dirWrite,
  input wire logic [WIDTH-1:0] dirIn,
  input wire logic pullWrite,
  input wire logic [WIDTH-1:0] pullIn,
  output logic [WIDTH-1:0] dataOut,
  // Pins
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] pinOut,
  output logic [WIDTH-1:0] pinOe,
  output logic [WIDTH-1:0] pullUpOn
);
  // ****************************************
  // Parameter check
  // ****************************************
  // Port words are at most one byte wide
  if (WIDTH < 1 || WIDTH > 8) begin : gBadWidth
    $error("bpp_port: WIDTH must be 1 to 8");
  end

  // ****************************************
  // Helper functions
  // ****************************************
  // Load a register on its write strobe, else hold
  function automatic logic [WIDTH-1:0] loadOrHold(
    input logic strobe,
    input logic [WIDTH-1:0] newValue,
    input logic [WIDTH-1:0] oldValue
  );
    logic [WIDTH-1:0] result;
    result = oldValue;
    if (strobe) begin
      result = newValue;
    end
    return result;
  endfunction : loadOrHold

  // Per bit: direction one picks outBits, zero picks inBits
  function automatic logic [WIDTH-1:0] selectByDir(
    input logic [WIDTH-1:0] dirBits,
    input logic [WIDTH-1:0] inBits,
    input logic [WIDTH-1:0] outBits
  );
    logic [WIDTH-1:0] result;
    result = (inBits & ~dirBits) | (outBits & dirBits);
    return result;
  endfunction : selectByDir

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [WIDTH-1:0] pinLevel;

  for (genvar i = 0; i < WIDTH; i++) begin : gSync
    bpp_pin_sync uSync (
      .clk(clk),
      .arst_n(arst_n),
      .pinIn(pinIn[i]),
      .level(pinLevel[i])
    );
  end

  // ****************************************
  // Port latch
  // ****************************************
  // Untouched by direction writes, so data survives mode changes
  logic [WIDTH-1:0] latch;
  logic [WIDTH-1:0] next_latch;

  always_comb begin
    next_latch = loadOrHold(dataWrite, dataIn, latch);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      latch <= bpp_pkg::LATCH_RESET[WIDTH-1:0];
    end else begin
      latch <= next_latch;
    end
  end

  // ****************************************
  // Direction register
  // ****************************************
  // Write-only: nothing below routes it to dataOut
  logic [WIDTH-1:0] dir;
  logic [WIDTH-1:0] next_dir;

  always_comb begin
    next_dir = loadOrHold(dirWrite, dirIn, dir);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dir <= bpp_pkg::DIR_RESET[WIDTH-1:0];
    end else begin
      dir <= next_dir;
    end
  end

  // ****************************************
  // Pull-up control register
  // ****************************************
  logic [WIDTH-1:0] pull;
  logic [WIDTH-1:0] next_pull;

  always_comb begin
    next_pull = loadOrHold(pullWrite, pullIn, pull);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pull <= bpp_pkg::PULL_RESET[WIDTH-1:0];
    end else begin
      pull <= next_pull;
    end
  end

  // ****************************************
  // Pin drive
  // ****************************************
  // Built from next values so pins follow the write edge
  logic [WIDTH-1:0] next_pinOut;
  logic [WIDTH-1:0] next_pinOe;

  always_comb begin
    next_pinOut = next_latch;
    next_pinOe = next_dir;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pinOut <= bpp_pkg::LATCH_RESET[WIDTH-1:0];
      pinOe <= bpp_pkg::DIR_RESET[WIDTH-1:0];
    end else begin
      pinOut <= next_pinOut;
      pinOe <= next_pinOe;
    end
  end

  // ****************************************
  // Pull-up drive
  // ****************************************
  // Output bits never get a pull-up, whatever pull holds
  logic [WIDTH-1:0] next_pullUpOn;

  always_comb begin
    next_pullUpOn = selectByDir(next_dir, next_pull, '0);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pullUpOn <= '0;
    end else begin
      pullUpOn <= next_pullUpOn;
    end
  end

  // ****************************************
  // Port read
  // ****************************************
  // Input bits show the pin, output bits show the latch
  logic [WIDTH-1:0] next_dataOut;

  always_comb begin
    next_dataOut = selectByDir(dir, pinLevel, latch);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dataOut <= '0;
    end else begin
      dataOut <= next_dataOut;
    end
  end
endmodule : bpp_port
`default_nettype wire
